// [src/dpb_defines.svh]
// Register indices, field positions, masks and reset values of the profile bank.
`ifndef DPB_DEFINES_SVH
`define DPB_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define DPB_COEF_A_MANT_LOW 12'h6c4
`define DPB_COEF_A_MANT_HIGH 12'h6c5
`define DPB_COEF_A_EXPONENTS 12'h6c6
`define DPB_COEF_B_MANT_BYTE0 12'h6c7
`define DPB_COEF_B_MANT_BYTE1 12'h6c8
`define DPB_COEF_B_EXP_MANT_TOP 12'h6c9
`define DPB_COEF_C_MANT_LOW 12'h6ca
`define DPB_COEF_C_MANT_HIGH 12'h6cb
`define DPB_COEF_C_EXP_MANT_TOP 12'h6cc
`define DPB_COEF_D_MANT_LOW 12'h6cd
`define DPB_COEF_D_MANT_HIGH 12'h6ce
`define DPB_COEF_AD_EXPONENTS 12'h6cf
`define DPB_INPUT_DIV_BYTE0 12'h6d0
`define DPB_INPUT_DIV_BYTE1 12'h6d1
`define DPB_INPUT_DIV_BYTE2 12'h6d2
`define DPB_INPUT_DIV_BYTE3 12'h6d3
`define DPB_FB_INT_DIV_BYTE0 12'h6d4
`define DPB_FB_INT_DIV_BYTE1 12'h6d5
`define DPB_FB_INT_DIV_BYTE2 12'h6d6
`define DPB_FB_INT_DIV_BYTE3 12'h6d7
`define DPB_FB_FRAC_BYTE0 12'h6d8
`define DPB_FB_FRAC_BYTE1 12'h6d9
`define DPB_FB_FRAC_BYTE2 12'h6da
`define DPB_PHASE_LOCK_THRESH_LOW 12'h6db
`define DPB_PHASE_LOCK_THRESH_HIGH 12'h6dc
`define DPB_PHASE_LOCK_FILL 12'h6dd
`define DPB_PHASE_LOCK_DRAIN 12'h6de
`define DPB_FREQ_LOCK_THRESH_BYTE0 12'h6df
`define DPB_FREQ_LOCK_THRESH_BYTE1 12'h6e0
`define DPB_FREQ_LOCK_THRESH_BYTE2 12'h6e1
`define DPB_FREQ_LOCK_FILL 12'h6e2
`define DPB_FREQ_LOCK_DRAIN 12'h6e3

// Profile spaces; the upper profile repeats the lower one's layout.
`define DPB_SPACE_LOW_START 12'h6b2
`define DPB_SPACE_LOW_END 12'h6ff
`define DPB_SPACE_HIGH_START 12'h7b2
`define DPB_SPACE_HIGH_END 12'h7ff
`define DPB_MIRROR_STEP 12'h100
`define DPB_STATUS 12'h800

// Writable bit masks: the full byte, and bytes that have unused bits.
`define DPB_MASK_FULL 8'hff
`define DPB_MASK_B_EXP_TOP 8'h7f
`define DPB_MASK_C_EXP_TOP 8'h3f
`define DPB_MASK_DIV_TOP 8'h3f
`define DPB_MASK_FRAC_BYTE1 8'hf3
`define DPB_MASK_FRAC_BYTE2 8'h3f

// Field positions inside shared bytes.
`define DPB_A_EXP1_LSB 0
`define DPB_A_EXP2_LSB 6
`define DPB_B_MANT_LSB 1
`define DPB_B_EXP_LSB 2
`define DPB_C_EXP_LSB 1
`define DPB_D_EXP_BIT0 7
`define DPB_A_EXP3_LSB 4

// Reset values and limits.
`define DPB_BYTE_RESET 8'h00
`define DPB_FB_DIV_MIN 30'h0000007

`endif

// [src/dpb_pkg.sv]
// Types shared by the profile bank.
package dpb_pkg;

    typedef enum logic {
        DPB_IDLE = 1'b0,
        DPB_DONE = 1'b1
    } dpb_phase_t;

    typedef struct packed {
        logic [15:0] a_mant;
        logic [5:0] a_exp1;
        logic [2:0] a_exp2;
        logic [3:0] a_exp3;
        logic [16:0] b_mant;
        logic [4:0] b_exp;
        logic [16:0] c_mant;
        logic [4:0] c_exp;
        logic [14:0] d_mant;
        logic [4:0] d_exp;
    } dpb_coef_t;

    typedef struct packed {
        dpb_coef_t coef;
        logic [29:0] in_div;
        logic [30:0] in_ratio;
        logic [29:0] fb_div;
        logic [30:0] fb_ratio;
        logic [15:0] phase_thresh;
        logic [7:0] phase_fill;
        logic [7:0] phase_drain;
        logic [23:0] freq_thresh;
        logic [7:0] freq_fill;
        logic [7:0] freq_drain;
    } dpb_prof_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } dpb_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dpb_apb_rsp_t;

    typedef struct packed {
        logic [1:0][31:0][7:0] mem;
        dpb_prof_t prof_low;
        dpb_prof_t prof_high;
        logic [1:0] fb_div_short;
        dpb_phase_t phase;
        dpb_apb_rsp_t rsp;
    } dpb_state_t;

endpackage

// [src/dpb_profile_bank.sv]
// APB register bank holding two loop filter, divider and lock detector profiles, lower and upper.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "dpb_defines.svh"

module dpb_profile_bank (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire dpb_pkg::dpb_apb_req_t apb_req,
    output dpb_pkg::dpb_apb_rsp_t apb_rsp,
    // Decoded profile values for the loop filter, dividers and lock detectors
    output dpb_pkg::dpb_prof_t prof_low,
    output dpb_pkg::dpb_prof_t prof_high,
    // Feedback divider below its legal minimum, per profile
    output logic [1:0] fb_div_short
);

    dpb_pkg::dpb_state_t st;
    dpb_pkg::dpb_state_t next_st;

    // Slot of a register inside one profile's storage.
    function automatic logic [4:0] slot(input logic [11:0] idx);
        logic [11:0] rel;
        rel = idx - `DPB_COEF_A_MANT_LOW;
        return rel[4:0];
    endfunction

    // Bits that software may set in a stored byte; the rest stay zero.
    function automatic logic [7:0] write_mask(input logic [4:0] s);
        logic [7:0] m;
        m = `DPB_MASK_FULL;
        if (s == slot(`DPB_COEF_B_EXP_MANT_TOP)) begin
            m = `DPB_MASK_B_EXP_TOP;
        end else if (s == slot(`DPB_COEF_C_EXP_MANT_TOP)) begin
            m = `DPB_MASK_C_EXP_TOP;
        end else if (s == slot(`DPB_INPUT_DIV_BYTE3)) begin
            m = `DPB_MASK_DIV_TOP;
        end else if (s == slot(`DPB_FB_INT_DIV_BYTE3)) begin
            m = `DPB_MASK_DIV_TOP;
        end else if (s == slot(`DPB_FB_FRAC_BYTE1)) begin
            m = `DPB_MASK_FRAC_BYTE1;
        end else if (s == slot(`DPB_FB_FRAC_BYTE2)) begin
            m = `DPB_MASK_FRAC_BYTE2;
        end
        return m;
    endfunction

    // Assemble one profile's fields from its stored bytes.
    function automatic dpb_pkg::dpb_prof_t decode(input logic [31:0][7:0] m);
        dpb_pkg::dpb_prof_t p;
        logic [7:0] a_exps;
        logic [7:0] b_b0;
        logic [7:0] b_top;
        logic [7:0] c_top;
        logic [7:0] d_hi;
        logic [7:0] ad_exps;
        a_exps = m[slot(`DPB_COEF_A_EXPONENTS)];
        b_b0 = m[slot(`DPB_COEF_B_MANT_BYTE0)];
        b_top = m[slot(`DPB_COEF_B_EXP_MANT_TOP)];
        c_top = m[slot(`DPB_COEF_C_EXP_MANT_TOP)];
        d_hi = m[slot(`DPB_COEF_D_MANT_HIGH)];
        ad_exps = m[slot(`DPB_COEF_AD_EXPONENTS)];
        // Each coefficient is an unsigned fraction scaled by two to its exponent.
        p.coef.a_mant = {m[slot(`DPB_COEF_A_MANT_HIGH)],
                         m[slot(`DPB_COEF_A_MANT_LOW)]};
        p.coef.a_exp1 = a_exps[`DPB_A_EXP1_LSB +: 6];
        p.coef.a_exp2 = {b_b0[0], a_exps[`DPB_A_EXP2_LSB +: 2]};
        p.coef.a_exp3 = ad_exps[`DPB_A_EXP3_LSB +: 4];
        p.coef.b_mant = {b_top[1:0], m[slot(`DPB_COEF_B_MANT_BYTE1)],
                         b_b0[`DPB_B_MANT_LSB +: 7]};
        p.coef.b_exp = b_top[`DPB_B_EXP_LSB +: 5];
        p.coef.c_mant = {c_top[0], m[slot(`DPB_COEF_C_MANT_HIGH)],
                         m[slot(`DPB_COEF_C_MANT_LOW)]};
        p.coef.c_exp = c_top[`DPB_C_EXP_LSB +: 5];
        p.coef.d_mant = {d_hi[6:0], m[slot(`DPB_COEF_D_MANT_LOW)]};
        p.coef.d_exp = {ad_exps[3:0], d_hi[`DPB_D_EXP_BIT0]};
        p.in_div = {m[slot(`DPB_INPUT_DIV_BYTE3)][5:0], m[slot(`DPB_INPUT_DIV_BYTE2)],
                    m[slot(`DPB_INPUT_DIV_BYTE1)], m[slot(`DPB_INPUT_DIV_BYTE0)]};
        p.in_ratio = {1'b0, p.in_div} + 31'h00000001;
        p.fb_div = {m[slot(`DPB_FB_INT_DIV_BYTE3)][5:0], m[slot(`DPB_FB_INT_DIV_BYTE2)],
                    m[slot(`DPB_FB_INT_DIV_BYTE1)], m[slot(`DPB_FB_INT_DIV_BYTE0)]};
        p.fb_ratio = {1'b0, p.fb_div} + 31'h00000001;
        p.phase_thresh = {m[slot(`DPB_PHASE_LOCK_THRESH_HIGH)],
                          m[slot(`DPB_PHASE_LOCK_THRESH_LOW)]};
        p.phase_fill = m[slot(`DPB_PHASE_LOCK_FILL)];
        p.phase_drain = m[slot(`DPB_PHASE_LOCK_DRAIN)];
        p.freq_thresh = {m[slot(`DPB_FREQ_LOCK_THRESH_BYTE2)],
                         m[slot(`DPB_FREQ_LOCK_THRESH_BYTE1)],
                         m[slot(`DPB_FREQ_LOCK_THRESH_BYTE0)]};
        p.freq_fill = m[slot(`DPB_FREQ_LOCK_FILL)];
        p.freq_drain = m[slot(`DPB_FREQ_LOCK_DRAIN)];
        return p;
    endfunction

    logic [11:0] idx;
    logic in_low_space;
    logic in_high_space;
    logic [11:0] base_idx;
    logic stored;
    logic hit_status;
    logic [4:0] acc_slot;
    logic acc_prof;

    always_comb begin
        idx = apb_req.paddr[13:2];
        in_low_space = (idx >= `DPB_SPACE_LOW_START) && (idx <= `DPB_SPACE_LOW_END);
        in_high_space = (idx >= `DPB_SPACE_HIGH_START) && (idx <= `DPB_SPACE_HIGH_END);
        // The upper profile uses the same slots one mirror step higher.
        base_idx = in_high_space ? idx - `DPB_MIRROR_STEP : idx;
        stored = (in_low_space || in_high_space) && (base_idx >= `DPB_COEF_A_MANT_LOW)
                 && (base_idx <= `DPB_FREQ_LOCK_DRAIN);
        hit_status = (idx == `DPB_STATUS) && (apb_req.paddr[15:14] == 2'b00);
        acc_slot = slot(base_idx);
        acc_prof = in_high_space;
    end

    always_comb begin
        next_st = st;
        case (st.phase)
            dpb_pkg::DPB_IDLE: begin
                next_st.rsp.pready = 1'b0;
                next_st.rsp.pslverr = 1'b0;
                if (apb_req.psel && apb_req.penable) begin
                    // Read data and the error flag are registered together with pready.
                    next_st.rsp.prdata = 32'h00000000;
                    if (apb_req.paddr[15:14] != 2'b00 || apb_req.paddr[1:0] != 2'b00) begin
                        next_st.rsp.pslverr = 1'b1;
                    end else if (stored) begin
                        next_st.rsp.prdata[7:0] = st.mem[acc_prof][acc_slot];
                    end else if (hit_status) begin
                        next_st.rsp.prdata[1:0] = st.fb_div_short;
                    end else if (!(in_low_space || in_high_space)) begin
                        next_st.rsp.pslverr = 1'b1;
                    end
                    next_st.rsp.pready = 1'b1;
                    next_st.phase = dpb_pkg::DPB_DONE;
                end
            end
            dpb_pkg::DPB_DONE: begin
                // The write lands on the edge that samples pready high.
                if (apb_req.psel && apb_req.penable && apb_req.pwrite && stored
                    && apb_req.pstrb[0] && !st.rsp.pslverr) begin
                    next_st.mem[acc_prof][acc_slot] =
                        apb_req.pwdata[7:0] & write_mask(acc_slot);
                end
                next_st.rsp.pready = 1'b0;
                next_st.rsp.pslverr = 1'b0;
                next_st.phase = dpb_pkg::DPB_IDLE;
            end
            default: begin
                next_st.phase = dpb_pkg::DPB_IDLE;
                next_st.rsp.pready = 1'b0;
            end
        endcase
        next_st.prof_low = decode(next_st.mem[0]);
        next_st.prof_high = decode(next_st.mem[1]);
        // Flags a feedback divider that software left below its minimum.
        next_st.fb_div_short[0] = next_st.prof_low.fb_div < `DPB_FB_DIV_MIN;
        next_st.fb_div_short[1] = next_st.prof_high.fb_div < `DPB_FB_DIV_MIN;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.mem <= {64{`DPB_BYTE_RESET}};
            st.prof_low <= '0;
            st.prof_high <= '0;
            st.fb_div_short <= 2'b11;
            st.phase <= dpb_pkg::DPB_IDLE;
            st.rsp <= '0;
            st.prof_low.in_ratio <= 31'h00000001;
            st.prof_low.fb_ratio <= 31'h00000001;
            st.prof_high.in_ratio <= 31'h00000001;
            st.prof_high.fb_ratio <= 31'h00000001;
        end else begin
            st <= next_st;
        end
    end

    assign apb_rsp = st.rsp;
    assign prof_low = st.prof_low;
    assign prof_high = st.prof_high;
    assign fb_div_short = st.fb_div_short;

endmodule

// [tb/dpb_profile_bank_monitor.sv]
// Checker for the profile bank's bus answers and decoded outputs.
`timescale 1ns/1ps
`include "dpb_defines.svh"
module dpb_profile_bank_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus and decoded outputs
    input wire dpb_pkg::dpb_apb_req_t apb_req,
    input wire dpb_pkg::dpb_apb_rsp_t apb_rsp,
    input wire dpb_pkg::dpb_prof_t prof_low,
    input wire dpb_pkg::dpb_prof_t prof_high,
    input wire logic [1:0] fb_div_short
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence answer_s;
        apb_rsp.pready && apb_req.psel && apb_req.penable;
    endsequence
    sequence wr_a_low_s;
        answer_s ##0 (apb_req.pwrite && apb_req.pstrb[0]
            && apb_req.paddr == {2'b00, `DPB_COEF_A_MANT_LOW, 2'b00});
    endsequence
    ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held longer than one cycle");
    answer_time_a: assert property ($rose(apb_req.penable) |=> apb_rsp.pready)
        else $error("ready not one cycle into the access phase");
    upper_zero_a: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    range_err_a: assert property (answer_s ##0 (apb_req.paddr[13:2] > 12'h800) |-> apb_rsp.pslverr)
        else $error("unmapped index not refused");
    err_data_a: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h00000000)
        else $error("refused access returned data");
    in_ratio_a: assert property (prof_low.in_ratio == {1'b0, prof_low.in_div} + 31'h1)
        else $error("input ratio not value plus one");
    fb_ratio_a: assert property (prof_low.fb_ratio == {1'b0, prof_low.fb_div} + 31'h1)
        else $error("feedback ratio not value plus one");
    short_flag_a: assert property (fb_div_short[0] == (prof_low.fb_div < 30'h0000007))
        else $error("short divider flag wrong");
    mirror_ratio_a: assert property (prof_high.in_ratio == {1'b0, prof_high.in_div} + 31'h1
        && fb_div_short[1] == (prof_high.fb_div < 30'h0000007))
        else $error("upper profile decode wrong");
    coef_write_a: assert property (wr_a_low_s |-> ##2
        prof_low.coef.a_mant[7:0] == $past(apb_req.pwdata[7:0], 2))
        else $error("written mantissa byte not decoded");
endmodule

bind dpb_profile_bank dpb_profile_bank_monitor mon (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .prof_low(prof_low), .prof_high(prof_high),
    .fb_div_short(fb_div_short));

// [tb/dpb_profile_bank_tb.sv]
// Self-checking bench that drives the profile bank over APB.
`timescale 1ns/1ps
`include "dpb_defines.svh"
module dpb_profile_bank_tb;
    logic pclk;
    logic presetn;
    dpb_pkg::dpb_apb_req_t apb_req;
    dpb_pkg::dpb_apb_rsp_t apb_rsp;
    dpb_pkg::dpb_prof_t prof_low;
    dpb_pkg::dpb_prof_t prof_high;
    logic [1:0] fb_div_short;
    logic [31:0] rd;
    logic rd_err;
    logic [3:0] strb = 4'hf;
    logic [1:0] addr_low = 2'b00;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    dpb_profile_bank dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .prof_low(prof_low), .prof_high(prof_high),
        .fb_div_short(fb_div_short));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    // One APB transfer; it returns one idle cycle after the answer.
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] data);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, addr_low},
            pwdata: {24'h000000, data}, pstrb: strb};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        rd_err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [7:0] pat(input logic [7:0] seed, input int i);
        return seed + 8'(i) * 8'h3b;
    endfunction
    function automatic logic [7:0] msk(input int i);
        case (i)
            5: return 8'h7f;
            8, 15, 19, 22: return 8'h3f;
            21: return 8'hf3;
            default: return 8'hff;
        endcase
    endfunction
    task automatic fill_and_read(input logic [11:0] base, input logic [7:0] seed);
        for (int i = 0; i < 32; i++) xfer(1'b1, base + 12'(i), pat(seed, i));
        for (int i = 0; i < 32; i++) begin
            xfer(1'b0, base + 12'(i), 8'h00);
            check(rd, {24'h000000, pat(seed, i) & msk(i)});
        end
    endtask
    task automatic check_prof(input dpb_pkg::dpb_prof_t p, input logic [7:0] seed);
        logic [7:0] b [32];
        for (int i = 0; i < 32; i++) b[i] = pat(seed, i);
        check(32'(p.coef.a_mant), 32'({b[1], b[0]}));
        check(32'(p.coef.a_exp1), 32'(b[2][5:0]));
        check(32'(p.coef.a_exp2), 32'({b[3][0], b[2][7:6]}));
        check(32'(p.coef.a_exp3), 32'(b[11][7:4]));
        check(32'(p.coef.b_mant), 32'({b[5][1:0], b[4], b[3][7:1]}));
        check(32'(p.coef.b_exp), 32'(b[5][6:2]));
        check(32'(p.coef.c_mant), 32'({b[8][0], b[7], b[6]}));
        check(32'(p.coef.c_exp), 32'(b[8][5:1]));
        check(32'(p.coef.d_mant), 32'({b[10][6:0], b[9]}));
        check(32'(p.coef.d_exp), 32'({b[11][3:0], b[10][7]}));
        check(32'(p.in_ratio), 32'({b[15][5:0], b[14], b[13], b[12]}) + 32'h1);
        check(32'(p.fb_ratio), 32'({b[19][5:0], b[18], b[17], b[16]}) + 32'h1);
        check(32'(p.phase_thresh), 32'({b[24], b[23]}));
        check(32'({p.phase_fill, p.phase_drain}), 32'({b[25], b[26]}));
        check(32'(p.freq_thresh), 32'({b[29], b[28], b[27]}));
        check(32'({p.freq_fill, p.freq_drain}), 32'({b[30], b[31]}));
    endtask
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(prof_low.in_ratio), 32'h1);
        check(32'(fb_div_short), 32'h3);
        xfer(1'b0, `DPB_COEF_A_MANT_LOW, 8'h00);
        check(rd, 32'h0);
        fill_and_read(`DPB_COEF_A_MANT_LOW, 8'h5a);
        fill_and_read(`DPB_COEF_A_MANT_LOW + 12'h100, 8'hc3);
        check_prof(prof_low, 8'h5a);
        check_prof(prof_high, 8'hc3);
        check(32'(fb_div_short), 32'h0);
        // Writes with byte lane zero off, or at an unaligned address, must not land.
        strb = 4'h0;
        xfer(1'b1, `DPB_COEF_A_MANT_LOW, 8'h00);
        check(32'(rd_err), 32'h0);
        strb = 4'hf;
        addr_low = 2'b10;
        xfer(1'b1, `DPB_COEF_A_MANT_LOW, 8'h00);
        check({rd[30:0], rd_err}, 32'h1);
        addr_low = 2'b00;
        xfer(1'b0, `DPB_COEF_A_MANT_LOW, 8'h00);
        check(rd, {24'h000000, pat(8'h5a, 0)});
        for (int v = 6; v < 8; v++) begin
            xfer(1'b1, `DPB_FB_INT_DIV_BYTE0, 8'(v));
            for (int j = 1; j < 4; j++) xfer(1'b1, `DPB_FB_INT_DIV_BYTE0 + 12'(j), 8'h00);
            xfer(1'b0, `DPB_STATUS, 8'h00);
            check(rd, (v == 6) ? 32'h1 : 32'h0);
            check(32'(prof_low.fb_ratio), 32'(v + 1));
        end
        // Clearing the upper profile's feedback divider flags only the upper profile.
        for (int j = 0; j < 4; j++) begin
            xfer(1'b1, `DPB_FB_INT_DIV_BYTE0 + `DPB_MIRROR_STEP + 12'(j), 8'h00);
        end
        xfer(1'b0, `DPB_STATUS, 8'h00);
        check(rd, 32'h2);
        check(32'(prof_high.fb_ratio), 32'h1);
        xfer(1'b1, 12'h6e4, 8'hff);
        xfer(1'b0, 12'h6e4, 8'h00);
        check({rd[30:0], rd_err}, 32'h0);
        xfer(1'b0, 12'h900, 8'h00);
        check({rd[30:0], rd_err}, 32'h1);
        give_verdict();
    end
endmodule
